// ==== bench/tb_mpwm_top.sv ====
// self-checking bench for the multichannel pwm timer top
// assumes the avalon slave answers after its own wait cycles and pins are registered
module tb_mpwm_top
  import mpwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // signals and counters
  // ----------------------------------------------------------------
  logic            clk;
  logic            rst;
  logic [AW-1:0]   av_addr;
  logic            av_rd;
  logic            av_wr;
  logic [31:0]     av_wdata;
  logic [3:0]      av_be;
  logic [31:0]     av_rdata;
  logic            av_wait;
  logic [NCH-1:0]  pwm;
  int              miscompares;
  int              compares;
  int              cycles;
  int              hi[NCH];
  int              mx[NCH];

  mpwm_top i_mpwm_top (
    .core_clk_i        (clk),
    .rst_i             (rst),
    .avs_address_i     (av_addr),
    .avs_read_i        (av_rd),
    .avs_write_i       (av_wr),
    .avs_writedata_i   (av_wdata),
    .avs_byteenable_i  (av_be),
    .avs_readdata_o    (av_rdata),
    .avs_waitrequest_o (av_wait),
    .pwm_o             (pwm)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // hang guard, generous against the longest measuring window
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // avalon master tasks
  // ----------------------------------------------------------------
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    av_addr  <= a;
    av_wdata <= d;
    av_be    <= b;
    av_wr    <= 1'b1;
    do @(posedge clk); while (av_wait !== 1'b0);
    av_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    @(posedge clk);
    av_addr <= a;
    av_rd   <= 1'b1;
    do @(posedge clk); while (av_wait !== 1'b0);
    d = av_rdata;
    av_rd <= 1'b0;
    check(d, exp);
  endtask

  // ----------------------------------------------------------------
  // pin measurement: high cycles and longest high run per pin
  // ----------------------------------------------------------------
  task automatic measure(input int n);
    int run[NCH];
    int xs;
    xs = 0;
    for (int c = 0; c < NCH; c++) begin
      hi[c]  = 0;
      mx[c]  = 0;
      run[c] = 0;
    end
    repeat (n) begin
      @(posedge clk);
      // an unknown pin would otherwise pass as low
      if ($isunknown(pwm)) xs++;
      for (int c = 0; c < NCH; c++) begin
        if (pwm[c] === 1'b1) begin
          hi[c]++;
          run[c]++;
          if (run[c] > mx[c]) mx[c] = run[c];
        end else begin
          run[c] = 0;
        end
      end
    end
    check(xs, 0);
  endtask

  // window is a whole number of periods, so the phase does not matter
  function automatic int exp_edge(input int p, input int d, input int n);
    return (d >= p) ? n : (n / p) * d;
  endfunction

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  logic [7:0]  ra[11] = '{OFS_CTRL, OFS_POL, OFS_ALIGN, OFS_PCM, OFS_PER, OFS_PER + 8'h1C,
                          OFS_DUTY, OFS_DUTY + 8'h1C, 8'hFC, OFS_PER + 8'h01, OFS_CNT + 8'h1C};
  logic [31:0] rv[11] = '{{20'h0, RST_CHAIN, RST_EN}, {24'h0, RST_POL}, {24'h0, RST_ALIGN},
                          {24'h0, RST_PCM}, {24'h0, RST_PER}, {24'h0, RST_PER},
                          {24'h0, RST_DUTY}, {24'h0, RST_DUTY}, 32'h0, 32'h0, 32'h0};
  int dt[4] = '{0, 2, 5, 4};
  int per6[NCH] = '{2, 1, 3, 6, 2, 1, 2, 43};
  int du6[NCH]  = '{129, 0, 1, 5, 0, 1, 1, 42};
  int ex6[NCH]  = '{0, 129, 86, 215, 0, 256, 129, 252};

  initial begin
    rst = 1'b1;
    av_addr = 8'h00;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wdata = 32'h0;
    av_be = 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({24'h0, pwm}, 32'h0);
    for (int i = 0; i < 11; i++) rd_chk(ra[i], rv[i]);
    bus_wr(8'hF0, 32'hFFFF_FFFF, 4'hF);
    rd_chk(8'hF0, 32'h0);
    $display("test reset_values done");

    // four narrow channels, 0 %, mid and 100 % duty, rest disabled
    for (int c = 0; c < 4; c++) begin
      bus_wr(OFS_PER + 8'(4 * c), 32'(3 + c), 4'hF);
      bus_wr(OFS_DUTY + 8'(4 * c), 32'(dt[c]), 4'hF);
    end
    bus_wr(OFS_CTRL, 32'h0000_000F, 4'hF);
    rd_chk(OFS_CTRL, 32'h0000_000F);
    repeat (20) @(posedge clk);
    measure(60);
    for (int c = 0; c < NCH; c++) check(hi[c], (c < 4) ? exp_edge(3 + c, (c < 4) ? dt[c] : 0, 60) : 0);
    $display("test edge_independent done");

    // inverted level on channels 0 and 3
    bus_wr(OFS_POL, 32'h0000_00F6, 4'hF);
    repeat (10) @(posedge clk);
    measure(60);
    check(hi[0], 60);
    check(hi[3], 20);
    check(hi[1], 30);
    $display("test polarity done");

    // centre aligned ch1: period 4 duty 2 gives 3 of every 8 cycles
    bus_wr(OFS_POL, 32'h0000_00FF, 4'hF);
    bus_wr(OFS_ALIGN, 32'h0000_0002, 4'hF);
    repeat (20) @(posedge clk);
    measure(120);
    check(hi[1], 45);
    check(hi[3], 80);
    $display("test centre done");

    // pulse-code ch1: same density as edge mode but no run longer than one
    bus_wr(OFS_ALIGN, 32'h0000_0000, 4'hF);
    bus_wr(OFS_PCM, 32'h0000_0002, 4'hF);
    repeat (20) @(posedge clk);
    measure(120);
    check(hi[1], 60);
    check(mx[1], 1);
    check(hi[3], 80);
    $display("test pulse_code done");

    // chain field ignored without its byte lane
    bus_wr(OFS_PCM, 32'h0000_0000, 4'hF);
    bus_wr(OFS_CTRL, 32'h0000_05FF, 4'h1);
    rd_chk(OFS_CTRL, 32'h0000_00FF);
    // mixed: pairs 1:0 and 5:4 chained, the rest narrow
    for (int c = 0; c < NCH; c++) begin
      bus_wr(OFS_PER + 8'(4 * c), 32'(per6[c]), 4'hF);
      bus_wr(OFS_DUTY + 8'(4 * c), 32'(du6[c]), 4'hF);
    end
    bus_wr(OFS_CTRL, 32'h0000_05FF, 4'hF);
    rd_chk(OFS_CTRL, 32'h0000_05FF);
    repeat (300) @(posedge clk);
    measure(258);
    for (int c = 0; c < NCH; c++) check(hi[c], ex6[c]);
    rd_chk(OFS_CNT, 32'h0);
    $display("test chain_mix done");
    results();
  end
endmodule

// ==== core/mpwm_engine.sv ====
// one waveform engine: counter, edge/centre alignment, pulse-code mode, polarity
// assumes configuration is held stable by the register file between writes
module mpwm_engine
  import mpwm_pkg::*;
(
  input  wire logic          core_clk_i,
  input  wire logic          rst_i,
  input  wire mpwm_cfg_t     cfg_i,
  output logic               pin_o,
  output logic [EW-1:0]      cnt_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [EW-1:0] cnt_q, cnt_d;
  logic [EW-1:0] acc_q, acc_d;
  mpwm_dir_t     dir_q, dir_d;
  logic          act_q, act_d;
  logic          pin_q, pin_d;
  logic [EW:0]   sum;

  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    acc_d = acc_q;
    act_d = 1'b0;
    sum   = {1'b0, acc_q} + {1'b0, cfg_i.duty};
    if (!cfg_i.en || cfg_i.period == '0) begin
      cnt_d = '0;
      dir_d = MPWM_UP;
      acc_d = '0;
    end else if (cfg_i.pcm) begin
      // density output: carries spread evenly, less ripple than a single pulse
      if (sum >= {1'b0, cfg_i.period}) begin
        act_d = 1'b1;
        acc_d = EW'(sum - {1'b0, cfg_i.period});
      end else begin
        acc_d = sum[EW-1:0];
      end
    end else begin
      act_d = (cnt_q < cfg_i.duty);
      case (dir_q)
        MPWM_UP: begin
          if (!cfg_i.centre) begin
            cnt_d = (cnt_q >= EW'(cfg_i.period - 1'b1)) ? '0 : EW'(cnt_q + 1'b1);
          end else if (cnt_q >= cfg_i.period) begin
            dir_d = MPWM_DOWN;
            cnt_d = EW'(cnt_q - 1'b1);
          end else begin
            cnt_d = EW'(cnt_q + 1'b1);
          end
        end
        MPWM_DOWN: begin
          if (!cfg_i.centre || cnt_q == '0) begin
            dir_d = MPWM_UP;
            cnt_d = cfg_i.centre ? EW'(cnt_q + 1'b1) : '0;
          end else begin
            cnt_d = EW'(cnt_q - 1'b1);
          end
        end
        default: begin
          dir_d = MPWM_UP;
          cnt_d = '0;
        end
      endcase
    end
    pin_d = cfg_i.pol ? act_d : ~act_d;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      acc_q <= '0;
      dir_q <= MPWM_UP;
      act_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      dir_q <= dir_d;
      act_q <= act_d;
      pin_q <= pin_d;
    end
  end

  assign pin_o = pin_q;
  assign cnt_o = cnt_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_idle_clear;
    @(posedge core_clk_i) disable iff (rst_i)
    !cfg_i.en |=> (cnt_q == '0 && !act_q);
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("idle engine not cleared");

  property p_zero_off;
    @(posedge core_clk_i) disable iff (rst_i)
    (cfg_i.en && !cfg_i.pcm && cfg_i.duty == '0) |=> !act_q;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("zero duty drove active");

  property p_full_on;
    @(posedge core_clk_i) disable iff (rst_i)
    (cfg_i.en && !cfg_i.pcm && !cfg_i.centre && cfg_i.period != '0
     && cfg_i.duty >= cfg_i.period) [*2] |=> act_q;
  endproperty
  a_full_on: assert property (p_full_on) else $error("full duty not active");

  property p_pcm_full;
    @(posedge core_clk_i) disable iff (rst_i)
    (cfg_i.en && cfg_i.pcm && cfg_i.period != '0 && cfg_i.duty >= cfg_i.period
     && acc_q < cfg_i.period) |=> act_q;
  endproperty
  a_pcm_full: assert property (p_pcm_full) else $error("pcm full density lost");

  property p_polarity;
    @(posedge core_clk_i) disable iff (rst_i)
    ##1 (pin_q == ($past(cfg_i.pol) ? act_q : !act_q));
  endproperty
  a_polarity: assert property (p_polarity) else $error("pin polarity wrong");

  property p_edge_wrap;
    @(posedge core_clk_i) disable iff (rst_i)
    (cfg_i.en && !cfg_i.pcm && !cfg_i.centre && cfg_i.period != '0
     && cnt_q >= EW'(cfg_i.period - 1'b1)) |=> cnt_q == '0;
  endproperty
  a_edge_wrap: assert property (p_edge_wrap) else $error("edge counter did not restart");

  sequence s_top_reached;
    cfg_i.en && !cfg_i.pcm && cfg_i.centre && cfg_i.period > EW'(1)
    && dir_q == MPWM_UP && cnt_q == cfg_i.period;
  endsequence
  property p_centre_turn;
    @(posedge core_clk_i) disable iff (rst_i)
    s_top_reached ##1 (cfg_i.centre && cfg_i.en && !cfg_i.pcm)
      |-> dir_q == MPWM_DOWN && cnt_q == EW'($past(cnt_q) - 1'b1);
  endproperty
  a_centre_turn: assert property (p_centre_turn) else $error("centre counter did not turn");
endmodule

// ==== core/mpwm_pkg.sv ====
// shared constants, register map and carrier types of the multichannel pwm timer
// assumes a 32-bit avalon-mm slave port with byte addressing
package mpwm_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned NCH   = 8;
  localparam int unsigned NPAIR = 4;
  localparam int unsigned CW    = 8;
  localparam int unsigned EW    = 16;
  localparam int unsigned AW    = 8;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_POL    = 8'h04;
  localparam logic [7:0] OFS_ALIGN  = 8'h08;
  localparam logic [7:0] OFS_PCM    = 8'h0C;
  localparam logic [7:0] OFS_PER    = 8'h10;
  localparam logic [7:0] OFS_DUTY   = 8'h30;
  localparam logic [7:0] OFS_CNT    = 8'h50;
  localparam logic [7:0] BANK_SPAN  = 8'h20;

  // ctrl fields
  localparam int unsigned CTRL_EN_LSB    = 0;
  localparam int unsigned CTRL_CHAIN_LSB = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_EN    = 8'h00;
  localparam logic [3:0] RST_CHAIN = 4'h0;
  localparam logic [7:0] RST_POL   = 8'hFF;
  localparam logic [7:0] RST_ALIGN = 8'h00;
  localparam logic [7:0] RST_PCM   = 8'h00;
  localparam logic [7:0] RST_PER   = 8'hFF;
  localparam logic [7:0] RST_DUTY  = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MPWM_UP   = 2'b01,
    MPWM_DOWN = 2'b10
  } mpwm_dir_t;

  typedef struct packed {
    logic          en;
    logic          centre;
    logic          pol;
    logic          pcm;
    logic [EW-1:0] period;
    logic [EW-1:0] duty;
  } mpwm_cfg_t;
endpackage

// ==== core/mpwm_top.sv ====
// top of the multichannel pwm timer: avalon-mm register file, pair chaining, eight engines
// assumes the avalon master holds its request until waitrequest is sampled low
//
// Function
// - eight 8-bit channels, own counter, period, duty
// - independent continuous waveforms, duty zero to full, but centre aligned at the largest period stops one cycle short of full
// - pulse-code mode selectable per channel
// - per-channel programmable output active level
// - per-channel edge or centre alignment
// - adjacent pairs chain into 16-bit channels
// - any mix of narrow and chained channels
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
module mpwm_top
  import mpwm_pkg::*;
(
  input  wire logic           core_clk_i,
  input  wire logic           rst_i,
  input  wire logic [AW-1:0]  avs_address_i,
  input  wire logic           avs_read_i,
  input  wire logic           avs_write_i,
  input  wire logic [31:0]    avs_writedata_i,
  input  wire logic [3:0]     avs_byteenable_i,
  output logic [31:0]         avs_readdata_o,
  output logic                avs_waitrequest_o,
  output logic [NCH-1:0]      pwm_o
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // returns {hit, index} for an eight-word bank starting at base
  function automatic logic [3:0] bank_sel(input logic [AW-1:0] addr, input logic [AW-1:0] base);
    logic [AW-1:0] rel;
    rel = AW'(addr - base);
    bank_sel = {(addr >= base) && (rel < BANK_SPAN) && (addr[1:0] == 2'b00), rel[4:2]};
  endfunction

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // one wait state: readdata is registered, so the answer comes on the second edge
  logic        req;
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;

  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign avs_readdata_o    = rdata_q;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [NCH-1:0]   en_q, en_d;
  logic [NPAIR-1:0] chain_q, chain_d;
  logic [NCH-1:0]   pol_q, pol_d;
  logic [NCH-1:0]   align_q, align_d;
  logic [NCH-1:0]   pcm_q, pcm_d;
  logic [CW-1:0]    per_q [NCH];
  logic [CW-1:0]    per_d [NCH];
  logic [CW-1:0]    duty_q [NCH];
  logic [CW-1:0]    duty_d [NCH];
  logic [EW-1:0]    cnt [NCH];
  mpwm_cfg_t        cfg [NCH];

  logic [3:0] sel_per, sel_duty, sel_cnt;
  logic       wr_go, lane0, lane1;

  assign sel_per  = bank_sel(avs_address_i, OFS_PER);
  assign sel_duty = bank_sel(avs_address_i, OFS_DUTY);
  assign sel_cnt  = bank_sel(avs_address_i, OFS_CNT);
  // writes land only at the edge where waitrequest is seen low
  assign wr_go    = avs_write_i & ack_q;
  assign lane0    = avs_byteenable_i[0];
  assign lane1    = avs_byteenable_i[1];

  always_comb begin
    ack_d   = req & ~ack_q;
    rdata_d = rdata_q;
    en_d    = en_q;
    chain_d = chain_q;
    pol_d   = pol_q;
    align_d = align_q;
    pcm_d   = pcm_q;
    per_d   = per_q;
    duty_d  = duty_q;
    if (avs_read_i && !ack_q) begin
      // unmapped addresses read as zero
      rdata_d = 32'h0000_0000;
      if (avs_address_i == OFS_CTRL) begin
        rdata_d = {20'h0_0000, chain_q, en_q};
      end else if (avs_address_i == OFS_POL) begin
        rdata_d = {24'h00_0000, pol_q};
      end else if (avs_address_i == OFS_ALIGN) begin
        rdata_d = {24'h00_0000, align_q};
      end else if (avs_address_i == OFS_PCM) begin
        rdata_d = {24'h00_0000, pcm_q};
      end else if (sel_per[3]) begin
        rdata_d = {24'h00_0000, per_q[sel_per[2:0]]};
      end else if (sel_duty[3]) begin
        rdata_d = {24'h00_0000, duty_q[sel_duty[2:0]]};
      end else if (sel_cnt[3]) begin
        rdata_d = {16'h0000, cnt[sel_cnt[2:0]]};
      end
    end
    if (wr_go) begin
      if (avs_address_i == OFS_CTRL) begin
        if (lane0) en_d = avs_writedata_i[CTRL_EN_LSB +: NCH];
        if (lane1) chain_d = avs_writedata_i[CTRL_CHAIN_LSB +: NPAIR];
      end else if (lane0) begin
        if (avs_address_i == OFS_POL) begin
          pol_d = avs_writedata_i[NCH-1:0];
        end else if (avs_address_i == OFS_ALIGN) begin
          align_d = avs_writedata_i[NCH-1:0];
        end else if (avs_address_i == OFS_PCM) begin
          pcm_d = avs_writedata_i[NCH-1:0];
        end else if (sel_per[3]) begin
          per_d[sel_per[2:0]] = avs_writedata_i[CW-1:0];
        end else if (sel_duty[3]) begin
          duty_d[sel_duty[2:0]] = avs_writedata_i[CW-1:0];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      en_q    <= RST_EN;
      chain_q <= RST_CHAIN;
      pol_q   <= RST_POL;
      align_q <= RST_ALIGN;
      pcm_q   <= RST_PCM;
      for (int i = 0; i < NCH; i++) begin
        per_q[i]  <= RST_PER;
        duty_q[i] <= RST_DUTY;
      end
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
      en_q    <= en_d;
      chain_q <= chain_d;
      pol_q   <= pol_d;
      align_q <= align_d;
      pcm_q   <= pcm_d;
      per_q   <= per_d;
      duty_q  <= duty_d;
    end
  end

  // ----------------------------------------------------------------
  // channels and chaining
  // ----------------------------------------------------------------
  // a chained pair runs on the odd engine; the even engine is parked at its inactive level
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam int unsigned PAIR = i / 2;
    localparam bit          ODD  = (i % 2) == 1;
    // low half of the pair, named outright so engine 0 never indexes below zero
    localparam int unsigned LO   = PAIR * 2;
    logic joined;
    assign joined = chain_q[PAIR];

    always_comb begin
      cfg[i].centre = align_q[i];
      cfg[i].pol    = pol_q[i];
      cfg[i].pcm    = pcm_q[i];
      if (ODD && joined) begin
        cfg[i].en     = en_q[i];
        cfg[i].period = {per_q[i], per_q[LO]};
        cfg[i].duty   = {duty_q[i], duty_q[LO]};
      end else begin
        cfg[i].en     = en_q[i] & ~(!ODD && joined);
        cfg[i].period = {8'h00, per_q[i]};
        cfg[i].duty   = {8'h00, duty_q[i]};
      end
    end

    mpwm_engine u_eng (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .cfg_i      (cfg[i]),
      .pin_o      (pwm_o[i]),
      .cnt_o      (cnt[i])
    );
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_even_parked;
    @(posedge core_clk_i) disable iff (rst_i)
    chain_q[0] [*2] |-> cnt[0] == '0;
  endproperty
  a_even_parked: assert property (p_even_parked) else $error("chained low engine running");

  property p_mix_free;
    @(posedge core_clk_i) disable iff (rst_i)
    (!chain_q[1] && en_q[3] && en_q[2] && !align_q[2] && !pcm_q[2]
     && per_q[2] != 8'h00 && cnt[2] < EW'(per_q[2] - 1'b1)) |=> cnt[2] == EW'($past(cnt[2]) + 1'b1);
  endproperty
  a_mix_free: assert property (p_mix_free) else $error("unchained channel stalled");

  property p_bus_answer;
    @(posedge core_clk_i) disable iff (rst_i)
    (req && !ack_q) |=> !avs_waitrequest_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  // chained count must carry past the low byte
  property p_chain_carry;
    @(posedge core_clk_i) disable iff (rst_i)
    (chain_q[0] && en_q[1] && !align_q[1] && !$past(align_q[1]) && !pcm_q[1]
     && cnt[1] == 16'h00FF && {per_q[1], per_q[0]} > 16'h0100) |=> cnt[1] == 16'h0100;
  endproperty
  a_chain_carry: assert property (p_chain_carry) else $error("chained count wrapped");

  property p_pol_write;
    @(posedge core_clk_i) disable iff (rst_i)
    (wr_go && avs_address_i == OFS_POL && lane0) |=> pol_q == $past(avs_writedata_i[NCH-1:0]);
  endproperty
  a_pol_write: assert property (p_pol_write) else $error("polarity write lost");
endmodule
